// ---- rtl/psq_defs.svh ----
/*
 * sequencer constants: indices, codes, fields, resets.
 * assumes: included by bare name.
 */
`ifndef PSQ_DEFS_SVH
`define PSQ_DEFS_SVH
// Summary of operation
// - host command starts a measurement set
// - autonomous repeat; interrupt per set or crossing
// - up to three measurements, per channel list
// - per-measurement LED selection, any combination
// - optional threshold compare, interrupt on crossing
// - interrupt after complete set, ignoring thresholds
// - separate drive current per LED, changeable anytime
// - overflow loads all ones, flags response
// - data overflow does not latch
// - response overflow held until no-op command
// - commands still executed during overflow
// - integration time lengthened by configuration
// - three independent LED driver outputs
// - answer general call and its reset
// - seven-bit pointer, bit six stops increment
// - alert line open-drain, released after reset

// register word indices (byte address = index * 4)
`define PSQ_IDX_CTRL 6'h00
`define PSQ_IDX_CMD 6'h01
`define PSQ_IDX_RESP 6'h02
`define PSQ_IDX_CHANNEL_ENABLE_LIST 6'h03
`define PSQ_IDX_LEDSEL 6'h04
`define PSQ_IDX_LEDCUR 6'h05
`define PSQ_IDX_RATE 6'h06
`define PSQ_IDX_THR0 6'h07
`define PSQ_IDX_THR1 6'h08
`define PSQ_IDX_THR2 6'h09
`define PSQ_IDX_ADCCFG 6'h0a
`define PSQ_IDX_DATA0 6'h0b
`define PSQ_IDX_DATA1 6'h0c
`define PSQ_IDX_DATA2 6'h0d
`define PSQ_IDX_STAT 6'h0e
`define PSQ_IDX_MASK 6'h0f
`define PSQ_IDX_LAST 6'h0f

// command codes written to the command register
`define PSQ_CMD_NOP 8'h00
`define PSQ_CMD_FORCE 8'h05
`define PSQ_CMD_PAUSE 8'h09
`define PSQ_CMD_AUTO 8'h0d

// reset values of the configuration
`define PSQ_RST_CHANNEL_ENABLE_LIST 3'h7
`define PSQ_RST_LEDSEL 9'h111
`define PSQ_RST_LEDCUR 12'h111
`define PSQ_RST_RATE 16'h0100
`define PSQ_RST_THR 48'h0
`define PSQ_RST_INTEG 3'h0

// data and timing
`define PSQ_OVF_DATA 16'hffff
`define PSQ_TICK_ZERO 8'h00
`define PSQ_STAT_SET 3

// two-wire link
`define PSQ_I2C_ADDR 7'h5a
`define PSQ_GC_ADDR 7'h00
`define PSQ_GC_RESET 8'h06
`define PSQ_PTR_NOINC 6
`define PSQ_BITS_BYTE 4'h8
`define PSQ_BIT_LAST 4'h7

// bus responses
`define PSQ_OKAY 2'b00
`define PSQ_SLVERR 2'b10
`endif

// ---- rtl/psq_pkg.sv ----
/*
 * sequencer types: states and state records.
 * assumes: constants header on the include path.
 */
`include "psq_defs.svh"
package psq_pkg;

    // measurement sequencer states
    typedef enum logic [1:0] {
        seq_idle = 2'b00,
        seq_fire = 2'b01,
        seq_wait = 2'b10
    } psq_seq_e;

    // two-wire slave states
    typedef enum logic [2:0] {
        i2c_idle = 3'b000,
        i2c_rx = 3'b001,
        i2c_ack = 3'b010,
        i2c_tx = 3'b011,
        i2c_rack = 3'b100
    } psq_i2c_e;

    // software configuration
    typedef struct packed {
        logic thr_en;
        logic set_irq;
        logic [2:0] channel_enable_list;
        logic [8:0] ledsel;
        logic [11:0] ledcur;
        logic [15:0] rate;
        logic [47:0] thr;
        logic rng;
        logic [2:0] integ;
        logic [3:0] mask;
    } psq_cfg_s;

    // two-wire slave state
    typedef struct packed {
        logic scl1, scl2, scl3;
        logic sda1, sda2, sda3;
        psq_i2c_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [1:0] nbyte;
        logic rw;
        logic gc;
        logic [6:0] ptr;
        logic sda_oe_n;
        logic sda_o;
        logic wr_stb;
        logic [5:0] wr_idx;
        logic [7:0] wr_byte;
        logic gc_rst;
    } psq_i2c_s;

endpackage

// ---- rtl/psq_i2c.sv ----
/*
 * two-wire slave: address, general call, pointer, byte access.
 * assumes: raw pins; rd_byte is combinational from ptr_idx.
 */
`timescale 1ns/10ps
module psq_i2c
    import psq_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // register side
    input wire logic [7:0] rd_byte,
    output logic [5:0] ptr_idx,
    output logic wr_stb,
    output logic [5:0] wr_idx,
    output logic [7:0] wr_byte,
    output logic gc_rst
);

    localparam psq_i2c_s RST = '{st: i2c_idle, sda_oe_n: 1'b1, scl1: 1'b1, scl2: 1'b1,
        scl3: 1'b1, sda1: 1'b1, sda2: 1'b1, sda3: 1'b1, default: '0};

    psq_i2c_s c, next_c;
    logic rise, fall, start, stop;

    // pointer step unless increment is disabled
    function automatic logic [6:0] step(input logic [6:0] p);
        step = p[`PSQ_PTR_NOINC] ? p : {1'b0, p[5:0] + 6'h01};
    endfunction

    // line events from synced samples
    assign rise = c.scl2 & ~c.scl3;
    assign fall = ~c.scl2 & c.scl3;
    assign start = c.scl2 & c.scl3 & c.sda3 & ~c.sda2;
    assign stop = c.scl2 & c.scl3 & ~c.sda3 & c.sda2;

    // next state
    always_comb begin
        next_c = c;
        next_c.scl1 = scl_i;
        next_c.scl2 = c.scl1;
        next_c.scl3 = c.scl2;
        next_c.sda1 = sda_i;
        next_c.sda2 = c.sda1;
        next_c.sda3 = c.sda2;
        next_c.wr_stb = 1'b0;
        next_c.gc_rst = 1'b0;
        next_c.sda_o = 1'b0;
        if (start) begin
            next_c.st = i2c_rx;
            next_c.cnt = 4'h0;
            next_c.nbyte = 2'h0;
            next_c.sda_oe_n = 1'b1;
        end else if (stop) begin
            next_c.st = i2c_idle;
            next_c.sda_oe_n = 1'b1;
        end else begin
            unique case (c.st)
                i2c_idle: begin
                    next_c.sda_oe_n = 1'b1;
                end
                i2c_rx: begin
                    if (rise) begin
                        next_c.sh = {c.sh[6:0], c.sda2};
                        next_c.cnt = c.cnt + 4'h1;
                    end
                    if (fall && c.cnt == `PSQ_BITS_BYTE) begin
                        next_c.cnt = 4'h0;
                        next_c.st = i2c_ack;
                        next_c.sda_oe_n = 1'b0;
                        if (c.nbyte == 2'h0) begin
                            next_c.rw = c.sh[0];
                            next_c.gc = (c.sh[7:1] == `PSQ_GC_ADDR);
                            if (c.sh[7:1] != `PSQ_I2C_ADDR && !(c.sh[7:1] == `PSQ_GC_ADDR && !c.sh[0])) begin
                                next_c.st = i2c_idle;
                                next_c.sda_oe_n = 1'b1;
                            end
                        end else if (c.gc) begin
                            next_c.gc_rst = (c.nbyte == 2'h1) && (c.sh == `PSQ_GC_RESET);
                        end else if (c.nbyte == 2'h1) begin
                            next_c.ptr = c.sh[6:0];
                        end else begin
                            next_c.wr_stb = 1'b1;
                            next_c.wr_idx = c.ptr[5:0];
                            next_c.wr_byte = c.sh;
                            next_c.ptr = step(c.ptr);
                        end
                        if (c.nbyte != 2'h2) begin
                            next_c.nbyte = c.nbyte + 2'h1;
                        end
                    end
                end
                i2c_ack: begin
                    if (fall && c.rw) begin
                        next_c.sh = rd_byte;
                        next_c.sda_oe_n = rd_byte[7];
                        next_c.ptr = step(c.ptr);
                        next_c.cnt = 4'h0;
                        next_c.st = i2c_tx;
                    end else if (fall) begin
                        next_c.sda_oe_n = 1'b1;
                        next_c.st = i2c_rx;
                    end
                end
                i2c_tx: begin
                    if (fall && c.cnt == `PSQ_BIT_LAST) begin
                        next_c.sda_oe_n = 1'b1;
                        next_c.st = i2c_rack;
                    end else if (fall) begin
                        next_c.sda_oe_n = c.sh[6];
                        next_c.sh = {c.sh[6:0], 1'b0};
                        next_c.cnt = c.cnt + 4'h1;
                    end
                end
                i2c_rack: begin
                    if (rise) begin
                        next_c.rw = ~c.sda2; // master ack keeps reading
                        next_c.st = i2c_ack;
                    end
                end
                default: begin
                    next_c.st = i2c_idle;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c <= RST;
        end else begin
            c <= next_c;
        end
    end

    assign sda_o = c.sda_o;
    assign sda_oe_n = c.sda_oe_n;
    assign ptr_idx = c.ptr[5:0];
    assign wr_stb = c.wr_stb;
    assign wr_idx = c.wr_idx;
    assign wr_byte = c.wr_byte;
    assign gc_rst = c.gc_rst;

endmodule

// ---- rtl/psq_top.sv ----
/*
 * proximity measurement sequencer: register file,
 * bus slaves and measurement sequence.
 * assumes: converter handshake on aclk;
 * link pins raw.
 */
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module psq_top
    import psq_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // two-wire link pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // alert pin and interrupt
    output logic int_o,
    output logic int_oe_n,
    output logic irq,
    // converter
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [15:0] adc_data,
    input wire logic adc_ovf,
    output logic adc_range,
    output logic [2:0] adc_integ,
    // LED drivers
    output logic [2:0] led_en,
    output logic [11:0] led_cur
);

    //--------------------------------------------------------------
    // state record
    //--------------------------------------------------------------
    typedef struct packed {
        psq_cfg_s cfg;
        psq_seq_e seq;
        logic [1:0] ch;
        logic auto_on;
        logic pend;
        logic [23:0] tmr;
        logic [2:0] above;
        logic [2:0] ovf;
        logic [47:0] data;
        logic [3:0] stat;
        logic [2:0] led_en;
        logic adc_start;
        logic irq;
        logic int_oe_n;
        logic int_o;
        logic aw_ok;
        logic [5:0] aw_idx;
        logic aw_bad;
        logic w_ok;
        logic [31:0] wd;
        logic [3:0] ws;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } psq_top_s;

    localparam psq_cfg_s CFG_RST = '{channel_enable_list: `PSQ_RST_CHANNEL_ENABLE_LIST, ledsel: `PSQ_RST_LEDSEL,
        ledcur: `PSQ_RST_LEDCUR, rate: `PSQ_RST_RATE, thr: `PSQ_RST_THR,
        integ: `PSQ_RST_INTEG, default: '0};
    localparam psq_top_s RST = '{cfg: CFG_RST, seq: seq_idle, int_oe_n: 1'b1,
        awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

    psq_top_s c, next_c;

    //--------------------------------------------------------------
    // two-wire slave
    //--------------------------------------------------------------
    logic [5:0] i2c_ptr;
    logic i2c_wr;
    logic [5:0] i2c_idx;
    logic [7:0] i2c_byte;
    logic i2c_gc;
    logic [31:0] i2c_word;

    // link reads see the low byte of the addressed register
    assign i2c_word = rd_reg(c, i2c_ptr);

    psq_i2c u_i2c (
        .aclk(aclk),
        .aresetn(aresetn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_n(sda_oe_n),
        .rd_byte(i2c_word[7:0]),
        .ptr_idx(i2c_ptr),
        .wr_stb(i2c_wr),
        .wr_idx(i2c_idx),
        .wr_byte(i2c_byte),
        .gc_rst(i2c_gc)
    );

    //--------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------
    // byte-lane merge of new data over old
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
        input logic [3:0] s);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                merge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction

    // register read map; reserved bits read zero
    function automatic logic [31:0] rd_reg(input psq_top_s s, input logic [5:0] idx);
        rd_reg = 32'h0;
        unique case (idx)
            `PSQ_IDX_CTRL: rd_reg[1:0] = {s.cfg.set_irq, s.cfg.thr_en};
            `PSQ_IDX_RESP: rd_reg[5:0] = {s.auto_on, s.seq != seq_idle, 1'b0, s.ovf};
            `PSQ_IDX_CHANNEL_ENABLE_LIST: rd_reg[2:0] = s.cfg.channel_enable_list;
            `PSQ_IDX_LEDSEL: rd_reg[8:0] = s.cfg.ledsel;
            `PSQ_IDX_LEDCUR: rd_reg[11:0] = s.cfg.ledcur;
            `PSQ_IDX_RATE: rd_reg[15:0] = s.cfg.rate;
            `PSQ_IDX_THR0: rd_reg[15:0] = s.cfg.thr[15:0];
            `PSQ_IDX_THR1: rd_reg[15:0] = s.cfg.thr[31:16];
            `PSQ_IDX_THR2: rd_reg[15:0] = s.cfg.thr[47:32];
            `PSQ_IDX_ADCCFG: rd_reg[3:0] = {s.cfg.integ, s.cfg.rng};
            `PSQ_IDX_DATA0: rd_reg[15:0] = s.data[15:0];
            `PSQ_IDX_DATA1: rd_reg[15:0] = s.data[31:16];
            `PSQ_IDX_DATA2: rd_reg[15:0] = s.data[47:32];
            `PSQ_IDX_STAT: rd_reg[3:0] = s.stat;
            `PSQ_IDX_MASK: rd_reg[3:0] = s.cfg.mask;
            default: rd_reg = 32'h0;
        endcase
    endfunction

    //--------------------------------------------------------------
    // next state
    //--------------------------------------------------------------
    always_comb begin
        logic we;
        logic [5:0] widx;
        logic [31:0] m;
        logic go;
        logic hit;
        logic [5:0] ridx;
        we = 1'b0;
        widx = c.aw_idx;
        m = 32'h0;
        go = 1'b0;
        hit = 1'b0;
        ridx = araddr[7:2];
        next_c = c;
        next_c.adc_start = 1'b0;
        next_c.int_o = 1'b0;

        // axi aw and w, either order
        if (awvalid && c.awready) begin
            next_c.aw_ok = 1'b1;
            next_c.aw_idx = awaddr[7:2];
            next_c.aw_bad = (awaddr[7:2] > `PSQ_IDX_LAST);
        end
        if (wvalid && c.wready) begin
            next_c.w_ok = 1'b1;
            next_c.wd = wdata;
            next_c.ws = wstrb;
        end
        if (c.bvalid && bready) begin
            next_c.bvalid = 1'b0;
        end

        // link writes go first; an axi write waits one cycle
        if (i2c_wr) begin
            we = 1'b1;
            widx = i2c_idx;
            m = merge(rd_reg(c, i2c_idx), {24'h0, i2c_byte}, 4'h1);
        end else if (c.aw_ok && c.w_ok && !c.bvalid) begin
            we = !c.aw_bad;
            m = merge(rd_reg(c, c.aw_idx), c.wd, c.ws);
            next_c.aw_ok = 1'b0;
            next_c.w_ok = 1'b0;
            next_c.bvalid = 1'b1;
            next_c.bresp = c.aw_bad ? `PSQ_SLVERR : `PSQ_OKAY;
        end

        // register writes
        if (we) begin
            unique case (widx)
                `PSQ_IDX_CTRL: {next_c.cfg.set_irq, next_c.cfg.thr_en} = m[1:0];
                `PSQ_IDX_CMD: begin
                    // commands run whatever the overflow state
                    unique case (m[7:0])
                        `PSQ_CMD_NOP: next_c.ovf = 3'h0;
                        `PSQ_CMD_FORCE: go = 1'b1;
                        `PSQ_CMD_AUTO: next_c.auto_on = 1'b1;
                        `PSQ_CMD_PAUSE: next_c.auto_on = 1'b0;
                        default: go = 1'b0;
                    endcase
                end
                `PSQ_IDX_CHANNEL_ENABLE_LIST: next_c.cfg.channel_enable_list = m[2:0];
                `PSQ_IDX_LEDSEL: next_c.cfg.ledsel = m[8:0];
                `PSQ_IDX_LEDCUR: next_c.cfg.ledcur = m[11:0];
                `PSQ_IDX_RATE: next_c.cfg.rate = m[15:0];
                `PSQ_IDX_THR0: next_c.cfg.thr[15:0] = m[15:0];
                `PSQ_IDX_THR1: next_c.cfg.thr[31:16] = m[15:0];
                `PSQ_IDX_THR2: next_c.cfg.thr[47:32] = m[15:0];
                `PSQ_IDX_ADCCFG: {next_c.cfg.integ, next_c.cfg.rng} = m[3:0];
                `PSQ_IDX_STAT: next_c.stat = c.stat & ~m[3:0];
                `PSQ_IDX_MASK: next_c.cfg.mask = m[3:0];
                default: go = 1'b0;
            endcase
        end

        // axi read, answered next edge
        if (c.rvalid && rready) begin
            next_c.rvalid = 1'b0;
        end
        if (arvalid && c.arready) begin
            hit = (ridx <= `PSQ_IDX_LAST);
            next_c.rvalid = 1'b1;
            next_c.rdata = rd_reg(c, ridx);
            next_c.rresp = hit ? `PSQ_OKAY : `PSQ_SLVERR;
            if (ridx == `PSQ_IDX_STAT) begin
                next_c.stat = next_c.stat & ~c.stat;
            end
        end

        // general-call reset restores defaults
        if (i2c_gc) begin
            next_c.cfg = CFG_RST;
            next_c.auto_on = 1'b0;
        end

        // autonomous interval timer
        if (c.auto_on) begin
            if (c.tmr >= {c.cfg.rate, `PSQ_TICK_ZERO}) begin
                next_c.tmr = 24'h0;
                next_c.pend = 1'b1;
            end else begin
                next_c.tmr = c.tmr + 24'h1;
            end
        end else begin
            next_c.tmr = 24'h0;
            next_c.pend = 1'b0;
        end

        // sequence; sets after clears
        unique case (c.seq)
            seq_idle: begin
                if (go || c.pend) begin
                    next_c.pend = 1'b0;
                    next_c.ch = 2'h0;
                    next_c.seq = seq_fire;
                end
            end
            seq_fire: begin
                if (c.ch == 2'h3) begin
                    next_c.seq = seq_idle;
                    if (c.cfg.set_irq) begin
                        next_c.stat[`PSQ_STAT_SET] = 1'b1;
                    end
                end else if (c.cfg.channel_enable_list[c.ch]) begin
                    next_c.led_en = c.cfg.ledsel[c.ch*3 +: 3];
                    next_c.adc_start = 1'b1;
                    next_c.seq = seq_wait;
                end else begin
                    next_c.ch = c.ch + 2'h1;
                end
            end
            seq_wait: begin
                if (adc_done) begin
                    next_c.led_en = 3'h0;
                    next_c.data[c.ch*16 +: 16] = adc_ovf ? `PSQ_OVF_DATA : adc_data;
                    if (adc_ovf) begin
                        next_c.ovf[c.ch] = 1'b1;
                    end
                    next_c.above[c.ch] = (adc_data > c.cfg.thr[c.ch*16 +: 16]) | adc_ovf;
                    if (c.cfg.thr_en && (next_c.above[c.ch] != c.above[c.ch])) begin
                        next_c.stat[c.ch] = 1'b1;
                    end
                    next_c.ch = c.ch + 2'h1;
                    next_c.seq = seq_fire;
                end
            end
            default: begin
                next_c.seq = seq_idle;
            end
        endcase

        // channel handshakes and alert line
        next_c.awready = !next_c.aw_ok && !next_c.bvalid;
        next_c.wready = !next_c.w_ok && !next_c.bvalid;
        next_c.arready = !next_c.rvalid;
        next_c.irq = |(next_c.stat & next_c.cfg.mask);
        next_c.int_oe_n = !next_c.irq;
    end

    //--------------------------------------------------------------
    // state register
    //--------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c <= RST;
        end else begin
            c <= next_c;
        end
    end

    //--------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------
    // from the state record
    assign awready = c.awready;
    assign wready = c.wready;
    assign bvalid = c.bvalid;
    assign bresp = c.bresp;
    assign arready = c.arready;
    assign rvalid = c.rvalid;
    assign rdata = c.rdata;
    assign rresp = c.rresp;
    assign int_o = c.int_o;
    assign int_oe_n = c.int_oe_n;
    assign irq = c.irq;
    assign adc_start = c.adc_start;
    assign led_en = c.led_en;

    // converter and LED settings
    assign adc_range = c.cfg.rng;
    assign adc_integ = c.cfg.integ;
    assign led_cur = c.cfg.ledcur;

endmodule

// ---- dv/psq_checker.sv ----
/* port checker of psq_top.
   assumes: bound to psq_top, one clock aclk. */
`timescale 1ns/10ps
module psq_checker (
    // watched top ports
    input wire logic aclk, aresetn, awvalid, awready, bvalid, bready, arvalid, arready,
    input wire logic rvalid, rready, sda_o, int_o, int_oe_n, irq, adc_start, adc_done,
    input wire logic [7:0] awaddr,
    input wire logic [1:0] bresp,
    input wire logic [31:0] rdata,
    input wire logic [2:0] led_en
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // output relations
    property p_alert; int_oe_n == !irq; endproperty
    a_alert: assert property (p_alert) else $error("alert pin");
    property p_pulse; adc_start |=> !adc_start; endproperty
    a_pulse: assert property (p_pulse) else $error("start pulse");
    property p_ledoff; adc_done |=> led_en == 3'h0; endproperty
    a_ledoff: assert property (p_ledoff) else $error("leds lit");
    property p_od; !sda_o && !int_o; endproperty
    a_od: assert property (p_od) else $error("pin driven high");
    property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer");
    property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer");
    property p_rlat; arvalid && arready |=> rvalid && !arready; endproperty
    a_rlat: assert property (p_rlat) else $error("read latency");
    property p_err; awvalid && awready && awaddr[7:6] != 2'h0 |-> ##[1:4] bvalid && bresp == 2'h2; endproperty
    a_err: assert property (p_err) else $error("unmapped write");
    c_start: cover property (adc_start);
    c_irq: cover property ($rose(irq));
    c_led1: cover property (adc_done && led_en[1]);
endmodule
bind psq_top psq_checker chk_u (.*);

// ---- dv/psq_adc_model.sv ----
/* converter model: answers after 2 or 7 cycles.
   assumes: led_en one hot at each start. */
`timescale 1ns/10ps
module psq_adc_model (
    // design side
    input wire logic aclk,
    input wire logic adc_start,
    input wire logic [2:0] led_en,
    output logic adc_done = 1'h0,
    output logic adc_ovf = 1'h0,
    output logic [15:0] adc_data = 16'h0,
    // bench side
    input wire logic [47:0] d_val,
    input wire logic [2:0] d_ovf
);
    logic [3:0] cnt = 4'h0;
    logic slow = 1'h0;
    int ch = 0;
    // wait counter, short and long answers in turn
    always @(posedge aclk) begin
        if (adc_start) begin
            cnt <= slow ? 4'h7 : 4'h2;
            slow <= !slow;
            ch <= led_en[2] ? 2 : led_en[1] ? 1 : 0;
        end else if (cnt != 4'h0) cnt <= cnt - 4'h1;
        adc_done <= cnt == 4'h1 && !adc_start;
        adc_ovf <= cnt == 4'h1 && d_ovf[ch];
        adc_data <= cnt == 4'h1 ? d_val[16*ch +: 16] : ~adc_data;
    end
endmodule

// ---- dv/psq_top_tb.sv ----
/* bench of psq_top: bus and link master, converter model, reference.
   assumes: checker binds itself. */
`timescale 1ns/10ps
module psq_top_tb;
    logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic awready, wready, bvalid, arready, rvalid, sda_o, sda_oe_n, int_o, int_oe_n, irq;
    logic adc_start, adc_done, adc_ovf, adc_range, scl_i = '1, sda_m = '1;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rv, lfsr = 32'h83840e1e;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] adc_data;
    logic [2:0] adc_integ, led_en, d_ovf = '0, ro = '0, f, fired[$];
    logic [2:0] cl[3] = '{3'h7, 3'h3, 3'h3}, ov[3] = '{3'h0, 3'h2, 3'h0};
    logic [8:0] ls[3] = '{9'h111, 9'h054, 9'h054};
    logic [11:0] led_cur;
    logic [47:0] d_val = '0, dv;
    int error_cnt = 0, checks_done = 0, j;
    psq_top dut_u (.*, .sda_i(sda_m & sda_oe_n));
    psq_adc_model adc_u (.*);
    // clock and record of leds at each start
    initial forever #5 aclk = ~aclk;
    always @(posedge aclk) if (adc_start === 1'h1) fired.push_back(led_en);
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task wr(input logic [5:0] i, input logic [31:0] d);
        awaddr <= {i, 2'h0};
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do @(posedge aclk); while (awready !== 1'h1);
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        bready <= 1'h1;
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 1'h0;
    endtask
    task rd(input logic [5:0] i);
        araddr <= {i, 2'h0};
        arvalid <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        rready <= 1'h1;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rv = rdata;
        rs = rresp;
        rready <= 1'h0;
    endtask
    // link frame with ack slots
    task fr(input logic [23:0] s, input int n);
        sda_m <= 1'h0;
        #62 scl_i <= 1'h0;
        for (int b = 0; b < 9 * n; b++) begin
            sda_m <= b % 9 == 8 ? 1'h1 : s[23 - b + b / 9];
            #31 scl_i <= 1'h1;
            #31 if (b % 9 == 8) chk("ack", 32'h0, sda_oe_n);
            #31 scl_i <= 1'h0;
            #32;
        end
        sda_m <= 1'h0;
        #31 scl_i <= 1'h1;
        #31 sda_m <= 1'h1;
        #63;
    endtask
    task tally_and_finish;
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(6'h03);
        chk("channel_enable_list", 32'h7, rv);
        rd(6'h20);
        chk("unmapped", 32'h2, rs);
        wr(6'h20, 32'h1);
        wr(6'h00, 32'h2);
        // one set per row
        for (int t = 0; t < 3; t++) begin
            lfsr = nxt(lfsr);
            dv = {lfsr[15:0], lfsr};
            d_val <= dv;
            d_ovf <= ov[t];
            wr(6'h03, cl[t]);
            wr(6'h04, ls[t]);
            fired.delete();
            wr(6'h01, 32'h5);
            repeat (3) @(posedge aclk);
            do rd(6'h02); while (rv[4] !== 1'h0);
            chk("irq", t != 0, irq);
            wr(6'h0f, 32'h8);
            rd(6'h0e);
            chk("set done", 32'h8, rv);
            for (int i = 0; i < 3; i++) if (cl[t][i]) begin
                f = ls[t][3*i +: 3];
                j = f[2] ? 2 : f[1] ? 1 : 0;
                chk("led", f, fired.pop_front());
                rd(6'(11 + i));
                chk("data", ov[t][j] ? 32'hffff : dv[16*j +: 16], rv);
                ro[i] = ro[i] | ov[t][j];
            end
            rd(6'h02);
            chk("resp", ro, rv[2:0]);
            $display("set %0d done", t);
        end
        wr(6'h01, 32'h0);
        rd(6'h02);
        chk("nop", 32'h0, rv[2:0]);
        lfsr = nxt(lfsr);
        wr(6'h0a, lfsr[3:0]);
        wr(6'h05, lfsr[15:4]);
        chk("range", lfsr[0], adc_range);
        chk("integ", lfsr[3:1], adc_integ);
        chk("led cur", lfsr[15:4], led_cur);
        fr({8'hb4, 8'h45, 8'h22}, 3);
        chk("link write", {lfsr[15:12], 8'h22}, led_cur);
        fr({8'h00, 8'h06, 8'h00}, 2);
        chk("general reset", 32'h111, led_cur);
        $display("link done");
        tally_and_finish();
    end
endmodule
